//--- include/tcs_pkg.sv
// Shared constants, field layouts and types of the trip circuit supervisor
package tcs_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_FREQ_HZ        = 100_000_000;
  localparam int unsigned SAMPLE_TIME_MS     = 500;
  localparam int unsigned SAMPLE_CYCLES      = CLK_FREQ_HZ / 1000 * SAMPLE_TIME_MS;
  localparam int unsigned SAMPLES_PER_SECOND = 1000 / SAMPLE_TIME_MS;
  localparam int unsigned PRESCALE_W         = 26;
  localparam logic [5:0]  DUAL_SAMPLES       = 6'h03;
  localparam logic [4:0]  DELAY_MIN_S        = 5'h01;
  localparam logic [4:0]  DELAY_MAX_S        = 5'h1E;
  localparam logic [4:0]  DELAY_RESET_S      = 5'h02;
  localparam int unsigned NUM_CIRCUITS       = 3;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [3:0]  ADDR_CTRL          = 4'h0;
  localparam logic [3:0]  ADDR_DELAY         = 4'h4;
  localparam logic [3:0]  ADDR_ROUTE         = 4'h8;
  localparam logic [3:0]  ADDR_STATUS        = 4'hC;

  // Control word fields and reset values
  localparam int unsigned CTRL_ENABLE_BIT    = 0;
  localparam int unsigned CTRL_DUAL_BIT      = 1;
  localparam int unsigned CTRL_COUNT_LSB     = 2;
  localparam logic        CTRL_ENABLE_RESET  = 1'b0;
  localparam logic        CTRL_DUAL_RESET    = 1'b1;
  localparam logic [1:0]  CTRL_COUNT_RESET   = 2'h1;

  // Routing word fields
  localparam int unsigned ROUTE_CONTACT_LSB  = 0;
  localparam int unsigned ROUTE_BREAKER_LSB  = 4;
  localparam logic [2:0]  ROUTE_RESET        = 3'h0;

  // Status word fields
  localparam int unsigned STAT_FAIL_LSB      = 0;
  localparam int unsigned STAT_ROUTE_LSB     = 4;
  localparam int unsigned STAT_OFF_BIT       = 8;
  localparam int unsigned STAT_ANY_BIT       = 9;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic       contact;
    logic       breaker;
  } tcs_sense_s;

  typedef enum logic [1:0] {
    TCS_CH_BLOCKED = 2'b00,
    TCS_CH_WATCH   = 2'b01,
    TCS_CH_FAILED  = 2'b10
  } tcs_ch_state_e;

endpackage

//--- logic/tcs_channel.sv
// Failure evaluator for one supervised trip circuit
`timescale 1ns/100ps
module tcs_channel (
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                ce_in,
  input  wire logic                sample_tick_in,
  input  wire logic                active_in,
  input  wire logic                suspend_in,
  input  wire logic                dual_mode_in,
  input  wire logic [4:0]          delay_s_in,
  input  wire tcs_pkg::tcs_sense_s sense_in,
  output logic                     fail_out
);

  tcs_pkg::tcs_ch_state_e state;
  logic [5:0]             count;
  logic                   abnormal;
  logic                   disagree;
  logic [5:0]             target;

  // ==========================================================================
  // Sample classification
  // ==========================================================================
  // Dual: only both-low is abnormal; single: a low contact input is abnormal
  assign abnormal = dual_mode_in ? (!sense_in.contact && !sense_in.breaker)
                                 : !sense_in.contact;
  assign disagree = abnormal != (state == tcs_pkg::TCS_CH_FAILED);
  // Single mode counts half-second ticks; one extra tick makes it strictly longer
  assign target   = dual_mode_in ? tcs_pkg::DUAL_SAMPLES
                                 : 6'({delay_s_in, 1'b0} + 6'h01);

  // ==========================================================================
  // Consecutive sample counter
  // ==========================================================================
  // Single mode restarts on any agreeing cycle, so the low must be continuous
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= 6'h00;
    end else if (ce_in) begin
      if (!active_in || suspend_in || state == tcs_pkg::TCS_CH_BLOCKED) begin
        count <= 6'h00;
      end else if (!dual_mode_in && !disagree) begin
        count <= 6'h00;
      end else if (sample_tick_in) begin
        if (!disagree || count + 6'h01 >= target) begin
          count <= 6'h00;
        end else begin
          count <= count + 6'h01;
        end
      end
    end
  end

  // ==========================================================================
  // Alarm state
  // ==========================================================================
  // Raise and clear use the same count, so the clear delay matches the raise
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= tcs_pkg::TCS_CH_BLOCKED;
    end else if (ce_in) begin
      if (!active_in) begin
        state <= tcs_pkg::TCS_CH_BLOCKED;
      end else begin
        case (state)
          tcs_pkg::TCS_CH_BLOCKED: begin
            state <= tcs_pkg::TCS_CH_WATCH;
          end
          tcs_pkg::TCS_CH_WATCH: begin
            if (!suspend_in && sample_tick_in && disagree && count + 6'h01 >= target) begin
              state <= tcs_pkg::TCS_CH_FAILED;
            end
          end
          tcs_pkg::TCS_CH_FAILED: begin
            if (!suspend_in && sample_tick_in && disagree && count + 6'h01 >= target) begin
              state <= tcs_pkg::TCS_CH_WATCH;
            end
          end
          default: begin
            state <= tcs_pkg::TCS_CH_BLOCKED;
          end
        endcase
      end
    end
  end

  assign fail_out = (state == tcs_pkg::TCS_CH_FAILED);

endmodule

//--- logic/tcs_supervisor.sv
// Trip circuit supervisor top: reset, prescaler, register slave and channels
//
// Overview of operation
// - Each circuit runs single-input or dual-input supervision as configured.
// - Inputs not routed to suit the mode raise that circuit's routing fault.
// - A circuit with a routing fault is blocked and evaluates no failures.
// - Up to three independent circuits, one per pole, each with own inputs.
// - Each circuit takes a contact sense input and, in dual mode, a breaker one.
// - Dual normal states: high/low, high/high and low/high.
// - Dual abnormal state is both inputs low; the only failure criterion.
// - Dual inputs are sampled about every half second.
// - Failure asserts after three consecutive abnormal samples; normal restarts.
// - Dual failure clears by itself after three consecutive normal samples.
// - Dual alarm latency is fixed near one to one and a half seconds, not the delay.
// - Single mode: high is normal, low only while trip contact briefly closes.
// - Single mode fails when input stays low longer than the alarm delay.
// - Single alarm delay is one to thirty seconds, default two.
// - Single failure clears by itself after the same configured delay.
// - Evaluation is suspended while a power-system fault is handled.
// - Enable defaults off; off shows an indication and gives no alarms.
// - Inputs per circuit is one or two, default two, and selects the mode.
// - Circuit count is configured; zero removes supervision entirely.
// - One failure output is asserted when any circuit has failed.
`timescale 1ns/100ps
module tcs_supervisor #(
  parameter int unsigned SAMPLE_CYCLES_P = tcs_pkg::SAMPLE_CYCLES
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clk_en_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        circuit1_contact_sense_in,
  input  wire logic        circuit1_breaker_sense_in,
  input  wire logic        circuit2_contact_sense_in,
  input  wire logic        circuit2_breaker_sense_in,
  input  wire logic        circuit3_contact_sense_in,
  input  wire logic        circuit3_breaker_sense_in,
  input  wire logic        system_fault_active_in,
  output logic             circuit1_routing_fault_out,
  output logic             circuit2_routing_fault_out,
  output logic             circuit3_routing_fault_out,
  output logic             supervision_off_indication_out,
  output logic             trip_circuit_fail_out
);

  localparam int unsigned NC = tcs_pkg::NUM_CIRCUITS;

  // Reset synchroniser
  logic                                rst_meta_n;
  logic                                rst_sync_n;

  // Prescaler
  logic [tcs_pkg::PRESCALE_W-1:0]      prescale;
  logic                                sample_tick;

  // Registers
  logic                                supervision_enable;
  logic                                dual_mode;
  logic [1:0]                          circuit_count;
  logic [4:0]                          alarm_delay_s;
  logic [NC-1:0]                       contact_routed;
  logic [NC-1:0]                       breaker_routed;

  // Bus handshake
  logic                                bus_ack;
  logic                                bus_req;
  logic                                wr_accept;
  logic [31:0]                         next_readdata;

  // Sense path and channel results
  logic [2*NC-1:0]                     sense_raw;
  logic [2*NC-1:0]                     sense_sync;
  logic [NC-1:0]                       circuit_present;
  logic [NC-1:0]                       routing_fault;
  logic [NC-1:0]                       channel_active;
  logic [NC-1:0]                       channel_fail;
  logic [NC-1:0]                       routing_fault_q;

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  // Keeps a written delay inside its legal range instead of refusing it
  function automatic logic [4:0] clamp_delay(input logic [4:0] value);
    logic [4:0] result;
    result = value;
    if (value < tcs_pkg::DELAY_MIN_S) begin
      result = tcs_pkg::DELAY_MIN_S;
    end else if (value > tcs_pkg::DELAY_MAX_S) begin
      result = tcs_pkg::DELAY_MAX_S;
    end
    return result;
  endfunction

  // Routing check: the contact input is always needed, the breaker input
  // must be routed exactly when two inputs per circuit are selected
  function automatic logic route_mismatch(input logic present, input logic dual,
                                          input logic has_contact, input logic has_breaker);
    return present && (!has_contact || (dual != has_breaker));
  endfunction

  // ==========================================================================
  // Reset release
  // ==========================================================================
  // Assertion is immediate, release passes two flops to avoid metastable exits
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else if (clk_en_in) begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ==========================================================================
  // Sample prescaler
  // ==========================================================================
  // Free-running so all circuits share one sampling phase
  always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prescale <= '0;
    end else if (clk_en_in) begin
      if (prescale == tcs_pkg::PRESCALE_W'(SAMPLE_CYCLES_P - 1)) begin
        prescale <= '0;
      end else begin
        prescale <= prescale + tcs_pkg::PRESCALE_W'(1);
      end
    end
  end

  // One-cycle tick every half second
  assign sample_tick = clk_en_in && (prescale == tcs_pkg::PRESCALE_W'(SAMPLE_CYCLES_P - 1));

  // ==========================================================================
  // Avalon-MM slave handshake
  // ==========================================================================
  // One wait state per access: the answer is given in the second cycle
  assign bus_req             = avs_read_in || avs_write_in;
  assign avs_waitrequest_out = bus_req && !bus_ack;
  assign wr_accept           = clk_en_in && avs_write_in && bus_ack && avs_byteenable_in[0];

  always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_ack <= 1'b0;
    end else if (clk_en_in) begin
      bus_ack <= bus_req && !bus_ack;
    end
  end

  // ==========================================================================
  // Control register
  // ==========================================================================
  // All fields sit in byte lane 0; other lanes are ignored
  always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      supervision_enable <= tcs_pkg::CTRL_ENABLE_RESET;
      dual_mode          <= tcs_pkg::CTRL_DUAL_RESET;
      circuit_count      <= tcs_pkg::CTRL_COUNT_RESET;
    end else if (wr_accept && avs_address_in == tcs_pkg::ADDR_CTRL) begin
      supervision_enable <= avs_writedata_in[tcs_pkg::CTRL_ENABLE_BIT];
      dual_mode          <= avs_writedata_in[tcs_pkg::CTRL_DUAL_BIT];
      circuit_count      <= avs_writedata_in[tcs_pkg::CTRL_COUNT_LSB +: 2];
    end
  end

  // ==========================================================================
  // Alarm delay register
  // ==========================================================================
  always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      alarm_delay_s <= tcs_pkg::DELAY_RESET_S;
    end else if (wr_accept && avs_address_in == tcs_pkg::ADDR_DELAY) begin
      alarm_delay_s <= clamp_delay(avs_writedata_in[4:0]);
    end
  end

  // ==========================================================================
  // Input routing register
  // ==========================================================================
  // Software declares which sense pins are actually wired for each circuit
  always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      contact_routed <= tcs_pkg::ROUTE_RESET;
      breaker_routed <= tcs_pkg::ROUTE_RESET;
    end else if (wr_accept && avs_address_in == tcs_pkg::ADDR_ROUTE) begin
      contact_routed <= avs_writedata_in[tcs_pkg::ROUTE_CONTACT_LSB +: NC];
      breaker_routed <= avs_writedata_in[tcs_pkg::ROUTE_BREAKER_LSB +: NC];
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  // Unmapped addresses read as zero; undefined bits read as zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address_in)
      tcs_pkg::ADDR_CTRL: begin
        next_readdata[tcs_pkg::CTRL_ENABLE_BIT]      = supervision_enable;
        next_readdata[tcs_pkg::CTRL_DUAL_BIT]        = dual_mode;
        next_readdata[tcs_pkg::CTRL_COUNT_LSB +: 2]  = circuit_count;
      end
      tcs_pkg::ADDR_DELAY: begin
        next_readdata[4:0]                           = alarm_delay_s;
      end
      tcs_pkg::ADDR_ROUTE: begin
        next_readdata[tcs_pkg::ROUTE_CONTACT_LSB +: NC] = contact_routed;
        next_readdata[tcs_pkg::ROUTE_BREAKER_LSB +: NC] = breaker_routed;
      end
      tcs_pkg::ADDR_STATUS: begin
        next_readdata[tcs_pkg::STAT_FAIL_LSB +: NC]  = channel_fail;
        next_readdata[tcs_pkg::STAT_ROUTE_LSB +: NC] = routing_fault_q;
        next_readdata[tcs_pkg::STAT_OFF_BIT]         = supervision_off_indication_out;
        next_readdata[tcs_pkg::STAT_ANY_BIT]         = trip_circuit_fail_out;
      end
      default: begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  // Captured on the first cycle so it stands when waitrequest drops
  always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (clk_en_in && avs_read_in && !bus_ack) begin
      avs_readdata_out <= next_readdata;
    end
  end

  // ==========================================================================
  // Sense input synchronisation
  // ==========================================================================
  assign sense_raw = {circuit3_contact_sense_in, circuit3_breaker_sense_in,
                      circuit2_contact_sense_in, circuit2_breaker_sense_in,
                      circuit1_contact_sense_in, circuit1_breaker_sense_in};

  tcs_sync #(
    .WIDTH    (2 * NC)
  ) u_sense_sync (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_sync_n),
    .ce_in    (clk_en_in),
    .async_in (sense_raw),
    .sync_out (sense_sync)
  );

  // ==========================================================================
  // Per-pole supervision channels
  // ==========================================================================
  // A circuit exists only below the configured count; zero disables all
  generate
    for (genvar i = 0; i < NC; i++) begin : g_circuit
      tcs_pkg::tcs_sense_s sense;

      assign circuit_present[i] = (circuit_count > 2'(i));
      assign routing_fault[i]   = route_mismatch(circuit_present[i], dual_mode,
                                                 contact_routed[i], breaker_routed[i]);
      assign channel_active[i]  = circuit_present[i] && supervision_enable
                                  && !routing_fault[i];
      assign sense.contact      = sense_sync[2*i+1];
      assign sense.breaker      = sense_sync[2*i];

      tcs_channel u_channel (
        .clk_in         (sys_clk_in),
        .rst_n_in       (rst_sync_n),
        .ce_in          (clk_en_in),
        .sample_tick_in (sample_tick),
        .active_in      (channel_active[i]),
        .suspend_in     (system_fault_active_in),
        .dual_mode_in   (dual_mode),
        .delay_s_in     (alarm_delay_s),
        .sense_in       (sense),
        .fail_out       (channel_fail[i])
      );
    end
  endgenerate

  // ==========================================================================
  // Indication outputs
  // ==========================================================================
  // Registered so the outputs never glitch while configuration changes
  always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      routing_fault_q                <= '0;
      supervision_off_indication_out <= 1'b0;
      trip_circuit_fail_out          <= 1'b0;
    end else if (clk_en_in) begin
      routing_fault_q                <= routing_fault;
      supervision_off_indication_out <= !supervision_enable;
      trip_circuit_fail_out          <= |channel_fail;
    end
  end

  assign circuit1_routing_fault_out = routing_fault_q[0];
  assign circuit2_routing_fault_out = routing_fault_q[1];
  assign circuit3_routing_fault_out = routing_fault_q[2];

endmodule

//--- logic/tcs_sync.sv
// Two-flop synchroniser for a group of asynchronous sense pins
`timescale 1ns/100ps
module tcs_sync #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // ==========================================================================
  // Synchroniser chain
  // ==========================================================================
  // First stage is read only by the second stage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta     <= '0;
      sync_out <= '0;
    end else if (ce_in) begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

//--- sim/tcs_supervisor_asserts.sv
// Port-level assertions for the trip circuit supervisor
`timescale 1ns/100ps
module tcs_supervisor_asserts #(
  parameter int unsigned SAMPLE_CYCLES_P = 8
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic circuit1_contact_sense_in,
  input wire logic circuit1_breaker_sense_in,
  input wire logic system_fault_active_in,
  input wire logic circuit1_routing_fault_out,
  input wire logic supervision_off_indication_out,
  input wire logic trip_circuit_fail_out
);
  // ====
  // Run lengths of circuit 1 pin states, saturating so a long run never wraps to short
  logic [15:0] lo_run;
  logic [15:0] hi_run;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lo_run <= 16'h0000;
      hi_run <= 16'h0000;
    end else begin
      lo_run <= circuit1_contact_sense_in ? 16'h0000 : lo_run + {15'h0000, ~&lo_run};
      hi_run <= (circuit1_contact_sense_in | circuit1_breaker_sense_in) ? hi_run + {15'h0000, ~&hi_run} : 16'h0000;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_rise_needs_run: assert property ($rose(trip_circuit_fail_out) |-> lo_run >= 2 * SAMPLE_CYCLES_P)
    else $error("alarm rose before a full abnormal run");
  chk_fall_needs_run: assert property ($fell(trip_circuit_fail_out) && !supervision_off_indication_out &&
    !circuit1_routing_fault_out |-> hi_run >= 2 * SAMPLE_CYCLES_P) else $error("alarm cleared too soon");
  chk_off_no_alarm: assert property (supervision_off_indication_out [*4] |-> !trip_circuit_fail_out)
    else $error("alarm while supervision off");
  chk_route_blocks: assert property (circuit1_routing_fault_out [*4] |-> !trip_circuit_fail_out)
    else $error("alarm on a blocked circuit");
  chk_fault_freeze: assert property (system_fault_active_in [*3] |-> $stable(trip_circuit_fail_out))
    else $error("alarm moved during a system fault");
  chk_off_default: assert property ($rose(rst_n_in) |-> ##6 supervision_off_indication_out)
    else $error("supervision not off after reset");
  chk_bus_one_wait: assert property ((avs_read_in | avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
  chk_reset_quiet: assert property (disable iff (1'b0) !rst_n_in |-> !trip_circuit_fail_out &&
    !circuit1_routing_fault_out && !supervision_off_indication_out) else $error("outputs active in reset");
  cover property ($rose(trip_circuit_fail_out));
  cover property ($fell(circuit1_routing_fault_out));
  cover property (system_fault_active_in [*3]);
endmodule
bind tcs_supervisor tcs_supervisor_asserts #(.SAMPLE_CYCLES_P(SAMPLE_CYCLES_P)) u_chk (.sys_clk_in, .rst_n_in,
  .avs_read_in, .avs_write_in, .avs_waitrequest_out, .circuit1_contact_sense_in, .circuit1_breaker_sense_in,
  .system_fault_active_in, .circuit1_routing_fault_out, .supervision_off_indication_out, .trip_circuit_fail_out);

//--- sim/tcs_supervisor_bench.sv
// Self-checking bench for the trip circuit supervisor
`timescale 1ns/100ps
module tcs_supervisor_bench;
  localparam int unsigned P = 8; // Short sample period keeps every alarm within a few hundred cycles
  logic sys_clk = 1'b0, rst_n = 1'b1, rd = 1'b0, wr = 1'b0, sysf = 1'b0, wreq, r1, r2, r3, off, fail;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [2:0] trip = 3'h0, cbon = 3'h7, brk = 3'h0, con, bkr;
  int num_errors = 0, cmp_count = 0;
  always #5 sys_clk = ~sys_clk;
  tcs_trip_model model (.trip_closed_in(trip), .cb_on_in(cbon), .broken_in(brk), .contact_out(con), .breaker_out(bkr));
  tcs_supervisor #(.SAMPLE_CYCLES_P(P)) dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .clk_en_in(1'b1),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .circuit1_contact_sense_in(con[0]),
    .circuit1_breaker_sense_in(bkr[0]), .circuit2_contact_sense_in(con[1]), .circuit2_breaker_sense_in(bkr[1]),
    .circuit3_contact_sense_in(con[2]), .circuit3_breaker_sense_in(bkr[2]), .system_fault_active_in(sysf),
    .circuit1_routing_fault_out(r1), .circuit2_routing_fault_out(r2), .circuit3_routing_fault_out(r3),
    .supervision_off_indication_out(off), .trip_circuit_fail_out(fail));
  // ====
  // Shared tasks
  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge; never assumes the wait length
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (wreq === 1'b0) break;
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n == 50) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic settle;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic wait_fail(input logic exp, input int lim);
    for (int n = 0; n < lim && fail !== exp; n++) @(posedge sys_clk);
    check({31'h0, fail}, {31'h0, exp});
    if (fail !== exp) end_sim();
  endtask
  // ====
  // Scenarios
  task automatic t_reset;
    bus(1'b0, tcs_pkg::ADDR_CTRL, 32'h0);
    check(q, 32'h6);
    bus(1'b0, tcs_pkg::ADDR_DELAY, 32'h0);
    check(q, 32'h2);
    bus(1'b0, tcs_pkg::ADDR_STATUS, 32'h0);
    check(q, 32'h110);
    bus(1'b0, 4'h2, 32'h0);
    check(q, 32'h0);
  endtask
  task automatic t_route;
    bus(1'b1, tcs_pkg::ADDR_ROUTE, 32'h77);
    bus(1'b1, tcs_pkg::ADDR_CTRL, 32'hF);
    settle();
    check({29'h0, r3, r2, r1}, 32'h0);
    bus(1'b1, tcs_pkg::ADDR_CTRL, 32'hD); // Single mode while breakers stay routed
    settle();
    check({29'h0, r3, r2, r1}, 32'h7);
    bus(1'b1, tcs_pkg::ADDR_CTRL, 32'h3);
    settle();
    check({29'h0, r3, r2, r1}, 32'h0);
  endtask
  task automatic t_dual;
    bus(1'b1, tcs_pkg::ADDR_ROUTE, 32'h11);
    bus(1'b1, tcs_pkg::ADDR_CTRL, 32'h7);
    trip <= 3'h1;
    cbon <= 3'h0;
    repeat (8 * P) @(posedge sys_clk);
    check({31'h0, fail}, 32'h0);
    trip <= 3'h0;
    cbon <= 3'h7;
    brk <= 3'h1;
    wait_fail(1'b1, 20 * P);
    brk <= 3'h0;
    wait_fail(1'b0, 20 * P);
  endtask
  task automatic t_single;
    bus(1'b1, tcs_pkg::ADDR_DELAY, 32'h0);
    bus(1'b0, tcs_pkg::ADDR_DELAY, 32'h0);
    check(q, 32'h1);
    bus(1'b1, tcs_pkg::ADDR_ROUTE, 32'h1);
    bus(1'b1, tcs_pkg::ADDR_CTRL, 32'h5);
    brk <= 3'h1;
    wait_fail(1'b1, 20 * P);
    bus(1'b0, tcs_pkg::ADDR_STATUS, 32'h0);
    check(q, 32'h201);
    brk <= 3'h0;
    wait_fail(1'b0, 20 * P);
  endtask
  task automatic t_sysfault;
    sysf <= 1'b1;
    brk <= 3'h1;
    repeat (12 * P) @(posedge sys_clk);
    check({31'h0, fail}, 32'h0);
    brk <= 3'h0;
    sysf <= 1'b0;
  endtask
  task automatic t_off;
    bus(1'b1, tcs_pkg::ADDR_CTRL, 32'h4);
    brk <= 3'h1;
    repeat (12 * P) @(posedge sys_clk);
    check({30'h0, off, fail}, 32'h2);
    brk <= 3'h0;
    bus(1'b1, tcs_pkg::ADDR_DELAY, 32'h1F);
    bus(1'b0, tcs_pkg::ADDR_DELAY, 32'h0);
    check(q, 32'h1E);
  endtask
  initial begin
    rst_n <= 1'b0; // A real falling edge clears every flop before the first clock edge
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_route();
    t_dual();
    t_single();
    t_sysfault();
    t_off();
    end_sim();
  end
endmodule

//--- sim/tcs_trip_model.sv
// Trip circuit contacts and breaker auxiliaries as seen at the sense pins
`timescale 1ns/100ps
module tcs_trip_model (
  input  wire logic [2:0] trip_closed_in,
  input  wire logic [2:0] cb_on_in,
  input  wire logic [2:0] broken_in,
  output logic      [2:0] contact_out,
  output logic      [2:0] breaker_out
);
  // A closed relay shorts the contact input; a closed breaker opens the breaker path; a broken loop kills both
  assign contact_out = ~trip_closed_in & ~broken_in;
  assign breaker_out = ~cb_on_in & ~broken_in;
endmodule
